// File: design/asqr_defs.svh
/*
 * Register offsets, field positions and reset values of the sequencer
 * stack register bank. Included by the package and the register logic.
 */
`ifndef ASQR_DEFS_SVH
`define ASQR_DEFS_SVH

// command word fields
`define ASQR_CMD_WR_BIT      15
`define ASQR_CMD_STACK_BIT   14
`define ASQR_CMD_IDX_HI      13
`define ASQR_CMD_IDX_LO      9
`define ASQR_CMD_DATA_HI     8

// register indices (stack space off)
`define ASQR_IDX_CONFIG      5'h02
`define ASQR_IDX_RANGE_B2    5'h07
`define ASQR_IDX_STATUS      5'h08

// stack byte addresses for reference
`define ASQR_STACK_FIRST     6'h20
`define ASQR_STACK_LAST      6'h3f

// stack level fields
`define ASQR_END_BIT         8
`define ASQR_LEVELS          32
`define ASQR_DEFAULT_PAIRS   8

// reset values
`define ASQR_RANGE_B2_RST    9'h0ff
`define ASQR_STACK_RST       9'h000
`define ASQR_CONFIG_RST      9'h000

// configuration bits
`define ASQR_CFG_BURST_BIT   6
`define ASQR_CFG_SEQEN_BIT   5
`define ASQR_CFG_STATUS_BIT  1

// channel select codes
`define ASQR_SEL_SUPPLY      4'h8
`define ASQR_SEL_REGULATOR   4'h9
`define ASQR_SEL_SELFTEST    4'hb

// self-test patterns
`define ASQR_TEST_PAT_A      16'haaaa
`define ASQR_TEST_PAT_B      16'h5555

`endif

// File: design/asqr_pkg.sv
/*
 * Types for the sequencer stack register bank.
 * Assumes asqr_defs.svh sits in the include path.
 */
`include "asqr_defs.svh"

package asqr_pkg;

   typedef enum logic [1:0] {
      ASQR_SPAN_10V_A = 2'b00,
      ASQR_SPAN_2V5   = 2'b01,
      ASQR_SPAN_5V    = 2'b10,
      ASQR_SPAN_10V_B = 2'b11
   } asqr_span_t;

   typedef enum logic [1:0] {
      ASQR_ST_IDLE  = 2'b00,
      ASQR_ST_CONV  = 2'b01,
      ASQR_ST_WAIT  = 2'b10
   } asqr_state_t;

   typedef struct packed {
      logic [8:0]                    cfg;
      logic [7:0]                    range_b2;
      logic [`ASQR_LEVELS-1:0][8:0]  stack;
      logic [4:0]                    level;
      asqr_state_t                   st;
      logic [3:0]                    last_a;
      logic [3:0]                    last_b;
      logic [15:0]                   rd_data;
      logic                          rd_valid;
      logic                          conv_go;
      logic [3:0]                    conv_a;
      logic [3:0]                    conv_b;
      logic [15:0]                   res_a;
      logic [15:0]                   res_b;
      logic                          res_valid;
      logic                          status_due;
   } asqr_state_reg_t;

endpackage : asqr_pkg

// File: design/asqr_regs.sv
/*
 * Register bank of the dual-ADC sequencer: configuration, ADC B upper
 * range register, 32-level sequencer stack and the read-only status word.
 * Assumes a host-interface front end that deframes 16-bit command words
 * into a one-cycle strobe on clk_sys, and an analog core that reports each
 * finished pair with conv_done.
 */
`timescale 1ns/1ps
`default_nettype none

`include "asqr_defs.svh"

// Overview of operation
// [RULE_01] range code 01 2.5V, 10 5V, else 10V
// [RULE_02] B upper range fields reset to three
// [RULE_03] address bit 14 selects 32 stack levels
// [RULE_04] each level holds one A/B pair
// [RULE_05] sequencer starts level one, steps, wraps
// [RULE_06] end flag level is last, then wrap
// [RULE_07] clear end flag advances to next level
// [RULE_08] reset loads pairs zero to seven looping
// [RULE_09] reset clears remaining 24 levels
// [RULE_10] select codes: inputs, supply, regulator monitors
// [RULE_11] code 1011 returns aaaa and 5555
// [RULE_12] A select bits 3:0, reset zero
// [RULE_13] stack at 0x20 to 0x3f, 16-bit
// [RULE_14] status word read only, writes ignored
// [RULE_15] status word appended when enable set
// [RULE_16] status 15:12 last A channel
// [RULE_17] status 11:8 last B channel
// [RULE_18] bit 15 one writes, zero reads
// [RULE_19] burst converts whole stack per pulse; code bursts only with sequencer enable bit 5 also set, else one pair
// [RULE_20] status low byte reads zero
module asqr_regs
   import asqr_pkg::*;
(
   input  wire logic        clk_sys,          // system clock, 200 MHz
   input  wire logic        rst,              // synchronous reset, high
   input  wire logic        clk_en,           // freezes all state when low
   input  wire logic        cmd_valid,        // one-cycle command strobe
   input  wire logic [15:0] cmd_word,         // host command word
   input  wire logic        conversion_start_pulse, // start pin, async
   input  wire logic        conv_done,        // analog pair finished
   input  wire logic [15:0] conv_code_a,      // raw ADC A code
   input  wire logic [15:0] conv_code_b,      // raw ADC B code
   output logic [15:0]      rd_data,          // register read answer
   output logic             rd_valid,         // read answer strobe
   output logic             conv_req,         // start pair conversion
   output logic [3:0]       first_adc_channel_select,  // ADC A select
   output logic [3:0]       second_adc_channel_select, // ADC B select
   output logic [15:0]      result_a,         // ADC A result word
   output logic [15:0]      result_b,         // ADC B result word
   output logic             result_valid,     // result strobe
   output logic             status_word_due,  // status follows results
   output logic [1:0]       adc_b_input_four, // span code input four
   output logic [1:0]       adc_b_input_five, // span code input five
   output logic [1:0]       adc_b_input_six,  // span code input six
   output logic [1:0]       adc_b_input_seven // span code input seven
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [8:0] asqr_default_level(input logic [4:0] idx);
      begin
         if (idx < 5'(`ASQR_DEFAULT_PAIRS)) begin
            asqr_default_level = {1'b0, idx[3:0], idx[3:0]};  // see [RULE_08]
            if (idx == 5'(`ASQR_DEFAULT_PAIRS - 1)) begin
               asqr_default_level[`ASQR_END_BIT] = 1'b1;      // see [RULE_08]
            end
         end else begin
            asqr_default_level = `ASQR_STACK_RST;             // see [RULE_09]
         end
      end
   endfunction : asqr_default_level

   function automatic logic [15:0] asqr_result(input logic [3:0] sel,
                                               input logic [15:0] code,
                                               input logic [15:0] pat);
      begin
         if (sel == `ASQR_SEL_SELFTEST) begin
            asqr_result = pat;                                // see [RULE_11]
         end else begin
            asqr_result = code;                               // see [RULE_10]
         end
      end
   endfunction : asqr_result

   function automatic logic asqr_is_last(input logic [8:0] lvl_word,
                                         input logic [4:0] idx);
      begin
         asqr_is_last = lvl_word[`ASQR_END_BIT] || idx == 5'h1f; // see [RULE_05] [RULE_06]
      end
   endfunction : asqr_is_last

   // ----------------------------------------------------------------
   // pin synchroniser and edge detect
   // ----------------------------------------------------------------
   logic start_s1_r;
   logic start_s2_r;
   logic start_s3_r;
   logic start_edge;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_s1_r <= 1'b0;
         start_s2_r <= 1'b0;
         start_s3_r <= 1'b0;
      end else if (clk_en) begin
         start_s1_r <= conversion_start_pulse;
         start_s2_r <= start_s1_r;
         start_s3_r <= start_s2_r;
      end
   end

   assign start_edge = start_s2_r & ~start_s3_r;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic       cmd_wr;
   logic       cmd_stack;
   logic [4:0] cmd_idx;
   logic [8:0] cmd_data;

   assign cmd_wr    = cmd_word[`ASQR_CMD_WR_BIT];             // see [RULE_18]
   assign cmd_stack = cmd_word[`ASQR_CMD_STACK_BIT];          // see [RULE_03]
   assign cmd_idx   = cmd_word[`ASQR_CMD_IDX_HI:`ASQR_CMD_IDX_LO];
   assign cmd_data  = cmd_word[`ASQR_CMD_DATA_HI:0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   asqr_state_reg_t s_r;
   asqr_state_reg_t s_nxt;
   logic [8:0]      cur_level;
   logic [15:0]     status_word;
   logic [7:0]      cur_pair;

   assign cur_level   = s_r.stack[s_r.level];
   assign cur_pair    = cur_level[7:0];
   assign status_word = {s_r.last_a, s_r.last_b, 8'h00};      // see [RULE_16] [RULE_17] [RULE_20]

   always_comb begin
      s_nxt           = s_r;
      s_nxt.rd_valid  = 1'b0;
      s_nxt.conv_go   = 1'b0;
      s_nxt.res_valid = 1'b0;
      s_nxt.status_due = 1'b0;

      // register access
      if (cmd_valid) begin
         if (cmd_wr) begin
            if (cmd_stack) begin
               s_nxt.stack[cmd_idx] = cmd_data;               // see [RULE_13] [RULE_12]
            end else if (cmd_idx == `ASQR_IDX_RANGE_B2) begin
               s_nxt.range_b2 = cmd_data[7:0];                // see [RULE_02]
            end else if (cmd_idx == `ASQR_IDX_CONFIG) begin
               s_nxt.cfg = cmd_data;
            end
            // status index falls through: read only         see [RULE_14]
         end else begin
            s_nxt.rd_valid = 1'b1;
            if (cmd_stack) begin
               s_nxt.rd_data = {cmd_word[15:9], s_r.stack[cmd_idx]};
            end else if (cmd_idx == `ASQR_IDX_RANGE_B2) begin
               s_nxt.rd_data = {cmd_word[15:9], 1'b0, s_r.range_b2};
            end else if (cmd_idx == `ASQR_IDX_CONFIG) begin
               s_nxt.rd_data = {cmd_word[15:9], s_r.cfg};
            end else if (cmd_idx == `ASQR_IDX_STATUS) begin
               s_nxt.rd_data = status_word;
            end else begin
               s_nxt.rd_data = 16'h0000;
            end
         end
      end

      // sequencer
      unique case (s_r.st)
         ASQR_ST_IDLE: begin
            if (start_edge) begin
               s_nxt.conv_go = 1'b1;
               s_nxt.conv_a  = cur_level[3:0];                // see [RULE_04]
               s_nxt.conv_b  = cur_level[7:4];
               s_nxt.st      = ASQR_ST_CONV;
            end
         end
         ASQR_ST_CONV: begin
            if (conv_done) begin
               s_nxt.res_valid = 1'b1;
               s_nxt.res_a  = asqr_result(s_r.conv_a, conv_code_a, `ASQR_TEST_PAT_A);
               s_nxt.res_b  = asqr_result(s_r.conv_b, conv_code_b, `ASQR_TEST_PAT_B);
               s_nxt.last_a = s_r.conv_a;                     // see [RULE_16]
               s_nxt.last_b = s_r.conv_b;                     // see [RULE_17]
               if (!s_r.cfg[`ASQR_CFG_SEQEN_BIT]) begin
                  s_nxt.level = s_r.level;
               end else if (asqr_is_last(cur_level, s_r.level)) begin
                  s_nxt.level = 5'h00;                        // see [RULE_06] [RULE_05]
               end else begin
                  s_nxt.level = s_r.level + 5'h01;            // see [RULE_07] [RULE_05]
               end
               if (s_r.cfg[`ASQR_CFG_SEQEN_BIT] && asqr_is_last(cur_level, s_r.level)) begin
                  s_nxt.status_due = s_r.cfg[`ASQR_CFG_STATUS_BIT]; // see [RULE_15]
               end else if (!s_r.cfg[`ASQR_CFG_SEQEN_BIT]) begin
                  s_nxt.status_due = s_r.cfg[`ASQR_CFG_STATUS_BIT];
               end
               s_nxt.st = ASQR_ST_WAIT;
            end
         end
         ASQR_ST_WAIT: begin
            if (s_r.cfg[`ASQR_CFG_BURST_BIT] && s_r.cfg[`ASQR_CFG_SEQEN_BIT] &&
                s_r.level != 5'h00) begin
               s_nxt.conv_go = 1'b1;                          // see [RULE_19]
               s_nxt.conv_a  = cur_level[3:0];
               s_nxt.conv_b  = cur_level[7:4];
               s_nxt.st      = ASQR_ST_CONV;
            end else begin
               s_nxt.st = ASQR_ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = ASQR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r.cfg        <= `ASQR_CONFIG_RST;
         s_r.range_b2   <= 8'(`ASQR_RANGE_B2_RST);            // see [RULE_02]
         for (int i = 0; i < `ASQR_LEVELS; i++) begin
            s_r.stack[i] <= asqr_default_level(5'(i));        // see [RULE_08] [RULE_09]
         end
         s_r.level      <= 5'h00;                             // see [RULE_05]
         s_r.st         <= ASQR_ST_IDLE;
         s_r.last_a     <= 4'h0;
         s_r.last_b     <= 4'h0;
         s_r.rd_data    <= 16'h0000;
         s_r.rd_valid   <= 1'b0;
         s_r.conv_go    <= 1'b0;
         s_r.conv_a     <= 4'h0;
         s_r.conv_b     <= 4'h0;
         s_r.res_a      <= 16'h0000;
         s_r.res_b      <= 16'h0000;
         s_r.res_valid  <= 1'b0;
         s_r.status_due <= 1'b0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rd_data                   = s_r.rd_data;
   assign rd_valid                  = s_r.rd_valid & clk_en;
   assign conv_req                  = s_r.conv_go & clk_en;
   assign first_adc_channel_select  = s_r.conv_a;
   assign second_adc_channel_select = s_r.conv_b;
   assign result_a                  = s_r.res_a;
   assign result_b                  = s_r.res_b;
   assign result_valid              = s_r.res_valid & clk_en;
   assign status_word_due           = s_r.status_due & clk_en;
   assign adc_b_input_four          = s_r.range_b2[1:0];      // see [RULE_01]
   assign adc_b_input_five          = s_r.range_b2[3:2];
   assign adc_b_input_six           = s_r.range_b2[5:4];
   assign adc_b_input_seven         = s_r.range_b2[7:6];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_end_done;
      s_r.st == ASQR_ST_CONV && conv_done && clk_en &&
      s_r.cfg[`ASQR_CFG_SEQEN_BIT] && cur_level[`ASQR_END_BIT];
   endsequence

   property p_wrap_on_end;
      @(posedge clk_sys) disable iff (rst) s_end_done |=> s_r.level == 5'h00;
   endproperty
   a_wrap_on_end: assert property (p_wrap_on_end) else $error("no wrap at end level"); // see [RULE_06]

   property p_advance;
      @(posedge clk_sys) disable iff (rst)
      (s_r.st == ASQR_ST_CONV && conv_done && clk_en && s_r.cfg[`ASQR_CFG_SEQEN_BIT] &&
       !cur_level[`ASQR_END_BIT] && s_r.level != 5'h1f)
      |=> s_r.level == $past(s_r.level) + 5'h01;
   endproperty
   a_advance: assert property (p_advance) else $error("level did not advance"); // see [RULE_07]

   property p_reset_stack;
      @(posedge clk_sys) rst |=> s_r.stack[3] == 9'h033 && s_r.stack[7] == 9'h177 &&
                                 s_r.stack[8] == 9'h000 && s_r.level == 5'h00;
   endproperty
   a_reset_stack: assert property (p_reset_stack) else $error("bad stack reset"); // see [RULE_08]

   property p_range_reset;
      @(posedge clk_sys) rst |=> adc_b_input_four == 2'b11 && adc_b_input_seven == 2'b11;
   endproperty
   a_range_reset: assert property (p_range_reset) else $error("bad range reset"); // see [RULE_02]

   property p_selftest;
      @(posedge clk_sys) disable iff (rst)
      (s_r.st == ASQR_ST_CONV && conv_done && clk_en && s_r.conv_a == `ASQR_SEL_SELFTEST)
      |=> result_a == `ASQR_TEST_PAT_A;
   endproperty
   a_selftest: assert property (p_selftest) else $error("self-test pattern wrong"); // see [RULE_11]

   property p_status_fields;
      @(posedge clk_sys) disable iff (rst)
      (s_r.st == ASQR_ST_CONV && conv_done && clk_en)
      |=> status_word[15:12] == $past(s_r.conv_a) && status_word[11:8] == $past(s_r.conv_b);
   endproperty
   a_status_fields: assert property (p_status_fields) else $error("status channel wrong"); // see [RULE_16]

   property p_status_low;
      @(posedge clk_sys) disable iff (rst)
      (cmd_valid && clk_en && !cmd_wr && !cmd_stack && cmd_idx == `ASQR_IDX_STATUS)
      |=> rd_data[7:0] == 8'h00 && rd_valid;
   endproperty
   a_status_low: assert property (p_status_low) else $error("status low byte nonzero"); // see [RULE_20]

   property p_stack_write;
      @(posedge clk_sys) disable iff (rst)
      (cmd_valid && clk_en && cmd_wr && cmd_stack)
      |=> s_r.stack[$past(cmd_idx)] == $past(cmd_data);
   endproperty
   a_stack_write: assert property (p_stack_write) else $error("stack write lost"); // see [RULE_03]

   property p_burst;
      @(posedge clk_sys) disable iff (rst)
      (s_r.st == ASQR_ST_WAIT && clk_en && s_r.cfg[`ASQR_CFG_BURST_BIT] &&
       s_r.cfg[`ASQR_CFG_SEQEN_BIT] && s_r.level != 5'h00) |=> conv_req;
   endproperty
   a_burst: assert property (p_burst) else $error("burst did not continue"); // see [RULE_19]

   sequence s_start_taken;
      s_r.st == ASQR_ST_IDLE && start_edge && clk_en;
   endsequence

   property p_start_pair;
      @(posedge clk_sys) disable iff (rst)
      s_start_taken |=> s_r.conv_go && {s_r.conv_b, s_r.conv_a} == $past(cur_pair);
   endproperty
   a_start_pair: assert property (p_start_pair) else $error("start pair wrong"); // see [RULE_04]

   property p_read_answer;
      @(posedge clk_sys) disable iff (rst)
      cmd_valid && clk_en |=> s_r.rd_valid == !$past(cmd_wr);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("bad rd strobe"); // see [RULE_18]

   property p_range_write;
      @(posedge clk_sys) disable iff (rst)
      (cmd_valid && clk_en && cmd_wr && !cmd_stack && cmd_idx == `ASQR_IDX_RANGE_B2)
      |=> s_r.range_b2 == 8'($past(cmd_data));
   endproperty
   a_range_write: assert property (p_range_write) else $error("range lost"); // see [RULE_02]

   property p_status_ro;
      @(posedge clk_sys) disable iff (rst)
      (cmd_valid && clk_en && cmd_wr && !cmd_stack && cmd_idx == `ASQR_IDX_STATUS &&
       !(s_r.st == ASQR_ST_CONV && conv_done)) |=> $stable(status_word);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status changed"); // see [RULE_14]

   property p_status_due;
      @(posedge clk_sys) disable iff (rst)
      (s_end_done ##0 s_r.cfg[`ASQR_CFG_STATUS_BIT]) |=> s_r.status_due && s_r.res_valid;
   endproperty
   a_status_due: assert property (p_status_due) else $error("no status due"); // see [RULE_15]

endmodule : asqr_regs

`default_nettype wire

// File: testbench/asqr_core_model.sv
/* analog core stand-in: takes each pair request and reports the
   finished pair after max_wait cycles with codes built from the selects.
   Assumes the register bank issues one request at a time. */
`timescale 1ns/1ps
`default_nettype none
module asqr_core_model (
   input  wire logic        clk_sys,   // system clock
   input  wire logic        rst,       // synchronous reset, high
   input  wire logic        conv_req,  // pair start strobe
   input  wire logic [3:0]  sel_a,     // ADC A select
   input  wire logic [3:0]  sel_b,     // ADC B select
   input  wire logic [3:0]  max_wait,  // answer delay, 1 to 8 cycles
   output logic             conv_done, // pair finished strobe
   output logic [15:0]      code_a,    // ADC A code
   output logic [15:0]      code_b     // ADC B code
);
   logic [3:0] a_q;
   logic [3:0] b_q;

   initial begin
      conv_done = 1'b0;
      code_a    = 16'h0000;
      code_b    = 16'hffff;
      forever begin
         @(negedge clk_sys);
         conv_done = 1'b0;
         code_a    = ~code_a; // no stale code outside the done cycle
         code_b    = ~code_b;
         if (conv_req && !rst) begin
            a_q = sel_a;
            b_q = sel_b;
            repeat (max_wait) begin
               @(negedge clk_sys);
               code_a = ~code_a;
               code_b = ~code_b;
            end
            conv_done = 1'b1;
            code_a    = {12'hc3a, a_q};
            code_b    = {12'h5c1, b_q};
         end
      end
   end
endmodule : asqr_core_model
`default_nettype wire

// File: testbench/adc_sequencer_stack_regs_bench.sv
/* self-checking bench of the sequencer stack register bank: defaults,
   register access, stepping and burst walks through the stack.
   Assumes asqr_core_model answers the conversion requests. */
`timescale 1ns/1ps
`default_nettype none
`include "asqr_defs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module adc_sequencer_stack_regs_bench;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic        cmd_valid = 1'b0;
   logic [15:0] cmd_word = 16'h0000;
   logic        start = 1'b0;
   logic [3:0]  max_wait = 4'h1;
   logic        conv_req, conv_done, rd_valid, result_valid, status_word_due;
   logic [15:0] code_a, code_b, rd_data, result_a, result_b, ex;
   logic [3:0]  sel_a, sel_b, last_a, last_b;
   logic [1:0]  span4, span5, span6, span7;
   logic [15:0] rd_q[$];
   logic [8:0]  cv_q[$];
   logic [8:0]  stk[32];
   logic [8:0]  cfg, ce, d9;
   logic [7:0]  rng, d;
   logic [4:0]  lvl;
   int          fails = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          i;
   integer      seed = 32'h1834;

   always #2.5 clk_sys = ~clk_sys;

   asqr_regs i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .conversion_start_pulse(start), .conv_done(conv_done),
      .conv_code_a(code_a), .conv_code_b(code_b), .rd_data(rd_data), .rd_valid(rd_valid),
      .conv_req(conv_req), .first_adc_channel_select(sel_a),
      .second_adc_channel_select(sel_b), .result_a(result_a), .result_b(result_b),
      .result_valid(result_valid), .status_word_due(status_word_due),
      .adc_b_input_four(span4), .adc_b_input_five(span5), .adc_b_input_six(span6),
      .adc_b_input_seven(span7));

   asqr_core_model i_core (.clk_sys(clk_sys), .rst(rst), .conv_req(conv_req), .sel_a(sel_a),
      .sel_b(sel_b), .max_wait(max_wait), .conv_done(conv_done), .code_a(code_a),
      .code_b(code_b));

   // ------------------------------------------------------------
   // host side tasks
   // ------------------------------------------------------------
   function automatic logic [15:0] rd_exp(input logic [15:0] w);
      if (w[14]) return {w[15:9], stk[w[13:9]]};
      if (w[13:9] == `ASQR_IDX_RANGE_B2) return {w[15:9], 1'b0, rng};
      if (w[13:9] == `ASQR_IDX_CONFIG) return {w[15:9], cfg};
      if (w[13:9] == `ASQR_IDX_STATUS) return {last_a, last_b, 8'h00};
      return 16'h0000;
   endfunction : rd_exp

   function automatic logic [15:0] res(input logic [3:0] s, input logic [15:0] p,
                                       input logic [11:0] hi);
      return (s == `ASQR_SEL_SELFTEST) ? p : {hi, s};
   endfunction : res

   task automatic cmd(input logic [15:0] w);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_word  = w;
      if (!clk_en) return;
      if (!w[15]) rd_q.push_back(rd_exp(w));
      else if (w[14]) stk[w[13:9]] = w[8:0];
      else if (w[13:9] == `ASQR_IDX_RANGE_B2) rng = w[7:0];
      else if (w[13:9] == `ASQR_IDX_CONFIG) cfg = w[8:0];
   endtask : cmd

   task automatic drain;
      int k;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      for (k = 0; k < 1000 && (rd_q.size() + cv_q.size()) > 0; k++) @(negedge clk_sys);
      if (k == 1000) begin
         fails++;
         $display("[ERR] queues exp empty got %0d", rd_q.size() + cv_q.size());
      end
   endtask : drain

   task automatic pulse;
      do begin
         cv_q.push_back({cfg[1] && (!cfg[5] || stk[lvl][8] || lvl == 5'd31), stk[lvl][3:0],
                         stk[lvl][7:4]});
         last_a = stk[lvl][3:0];
         last_b = stk[lvl][7:4];
         if (cfg[5]) lvl = (stk[lvl][8] || lvl == 5'd31) ? 5'd0 : lvl + 5'd1;
      end while (cfg[6] && cfg[5] && lvl != 5'd0);
      max_wait = 4'd1 + 4'($unsigned($random(seed)) % 8);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      start     = 1'b1;
      repeat (4) @(negedge clk_sys);
      start = 1'b0;
      drain();
   endtask : pulse

   task automatic chk_defaults;
      for (int j = 0; j < 32; j++) stk[j] = (j < 8) ? {j == 7, j[3:0], j[3:0]} : 9'h000;
      rng = 8'hff;
      cfg = 9'h000;
      lvl = 5'd0;
      last_a = 4'h0;
      last_b = 4'h0;
      for (int j = 0; j < 32; j++) cmd({2'b01, j[4:0], 9'h000});
      cmd(16'h0e00);
      cmd(16'h1000);
      drain();
      `CHK("span", 8'hff, {span7, span6, span5, span4})
   endtask : chk_defaults

   task automatic end_sim;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // ------------------------------------------------------------
   // output monitor
   // ------------------------------------------------------------
   always @(negedge clk_sys) begin
      if (!rst && rd_valid) begin
         ex = rd_q.size() ? rd_q.pop_front() : 16'hxxxx;
         `CHK("rd_data", ex, rd_data)
      end
      if (!rst && conv_req) begin
         ce = cv_q.size() ? cv_q[0] : 9'h1ff;
         `CHK("sel_a", ce[7:4], sel_a)
         `CHK("sel_b", ce[3:0], sel_b)
      end
      if (!rst && result_valid) begin
         ce = cv_q.size() ? cv_q.pop_front() : 9'h1ff;
         `CHK("result_a", res(ce[7:4], `ASQR_TEST_PAT_A, 12'hc3a), result_a)
         `CHK("result_b", res(ce[3:0], `ASQR_TEST_PAT_B, 12'h5c1), result_b)
         `CHK("status_due", ce[8], status_word_due)
      end
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         $display("[ERR] run length exp under 20000 got %0d", cyc);
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      chk_defaults();
      for (i = 0; i < 4; i++) begin
         d = {i[1:0], i[1:0] + 2'd1, i[1:0] + 2'd2, i[1:0] + 2'd3};
         cmd({2'b10, 5'd7, 1'b1, d});
         cmd(16'h0e00);
         drain();
         `CHK("span", d, {span7, span6, span5, span4})
      end
      cmd(16'h0200);
      cmd(16'h8422);
      cmd(16'h0400);
      repeat (10) pulse();
      cmd(16'h1000);
      cmd(16'h91ff);
      cmd(16'h1000);
      for (i = 0; i < 32; i++) begin
         d9 = {1'b0, 4'($unsigned($random(seed)) % 10), 4'($unsigned($random(seed)) % 10)};
         if (i == 20) d9[8] = 1'b1;
         if (i == 3) d9[7:0] = 8'hbb;
         cmd({2'b11, i[4:0], d9});
      end
      for (i = 0; i < 32; i++) cmd({2'b01, i[4:0], 9'h000});
      cmd(16'h8462);
      pulse();
      pulse();
      cmd({2'b11, 5'd20, stk[20] & 9'h0ff});
      pulse();
      cmd(16'h1000);
      drain();
      clk_en = 1'b0;
      cmd(16'h8e5a);
      drain();
      clk_en = 1'b1;
      cmd(16'h0e00);
      drain();
      // burst without sequencer: one pair per pulse, level holds
      cmd(16'h8442);
      pulse();
      pulse();
      cmd(16'h1000);
      drain();
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      chk_defaults();
      end_sim();
   end
endmodule : adc_sequencer_stack_regs_bench
`default_nettype wire
